// file: hw/aimrc_consts.svh
// constants for the converter input mux and reference control block
`ifndef AIMRC_CONSTS_SVH
`define AIMRC_CONSTS_SVH

// -----------------------------------------------------------------
// register addresses and reset values
// -----------------------------------------------------------------
`define AIMRC_ADDR_INSEL     8'hBB
`define AIMRC_ADDR_REFCTL    8'hD1
`define AIMRC_INSEL_RESET    8'h1F
`define AIMRC_REFCTL_RESET   8'h18
`define AIMRC_INSEL_WMASK    8'h1F
`define AIMRC_REFCTL_WMASK   8'hBC
`define AIMRC_RDATA_NONE     8'h00

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define AIMRC_INSEL_MSB      4
`define AIMRC_INSEL_LSB      0
`define AIMRC_REF_LEVEL_BIT  7
`define AIMRC_GND_SEL_BIT    5
`define AIMRC_REF_SRC_MSB    4
`define AIMRC_REF_SRC_LSB    3
`define AIMRC_TEMP_EN_BIT    2

// -----------------------------------------------------------------
// input select codes
// -----------------------------------------------------------------
`define AIMRC_CODE_EXT_LAST  5'h0F
`define AIMRC_CODE_INT_FIRST 5'h10
`define AIMRC_CODE_INT_LAST  5'h13
`define AIMRC_EXT_ONE        16'h0001
`define AIMRC_INT_ONE        4'h1

`endif

// file: hw/aimrc_pkg.sv
// types for the converter input mux and reference control block
package aimrc_pkg;

  // reference source encoding, in field order
  typedef enum logic [1:0] {
    aimrc_ref_ext_pin,
    aimrc_ref_supply_pin,
    aimrc_ref_digital_1v8,
    aimrc_ref_internal
  } aimrc_ref_src_t;

endpackage

// file: hw/aimrc_mux_decode.sv
// decoder from input select code to channel and internal source enables
`timescale 1ns/1ps
`include "aimrc_consts.svh"

module aimrc_mux_decode #(
  parameter int EXT_CHANNELS = 16,
  parameter int INT_SOURCES  = 4
) (
  input  wire logic [4:0]              code,
  output logic      [EXT_CHANNELS-1:0] ext_select,
  output logic      [INT_SOURCES-1:0]  int_select,
  output logic                         connected
);

  // -----------------------------------------------------------------
  // external channels and internal sources
  // -----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < EXT_CHANNELS; g++) begin : g_ext
      assign ext_select[g] = (code == 5'(g));
    end
    for (g = 0; g < INT_SOURCES; g++) begin : g_int
      assign int_select[g] = (code == (`AIMRC_CODE_INT_FIRST + 5'(g)));
    end
  endgenerate

  // -----------------------------------------------------------------
  // reserved codes select nothing
  // -----------------------------------------------------------------
  // reserved code disconnects
  assign connected = (code <= `AIMRC_CODE_INT_LAST);

endmodule

// file: hw/aimrc_top.sv
// converter input mux select and voltage reference control registers
`timescale 1ns/1ps
`include "aimrc_consts.svh"

module aimrc_top #(
  parameter int EXT_CHANNELS = 16,
  parameter int INT_SOURCES  = 4
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic [7:0]                  sfr_addr,
  input  wire logic [7:0]                  sfr_wdata,
  input  wire logic                        sfr_wr,
  input  wire logic                        sfr_rd,
  output logic      [7:0]                  sfr_rdata,
  output logic      [4:0]                  positive_input_select,
  output logic      [EXT_CHANNELS-1:0]     ext_channel_select,
  output logic      [INT_SOURCES-1:0]      internal_source_select,
  output logic                             positive_input_connected,
  output logic                             internal_ref_level,
  output logic                             ground_ref_select,
  output aimrc_pkg::aimrc_ref_src_t        reference_source_select,
  output logic                             temp_sensor_enable
);

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  logic                    wr_insel;
  logic                    wr_refctl;
  logic [4:0]              next_sel;
  logic [EXT_CHANNELS-1:0] next_ext;
  logic [INT_SOURCES-1:0]  next_int;
  logic                    next_connected;

  assign wr_insel  = sfr_wr && (sfr_addr == `AIMRC_ADDR_INSEL);
  assign wr_refctl = sfr_wr && (sfr_addr == `AIMRC_ADDR_REFCTL);
  assign next_sel  = wr_insel ? sfr_wdata[`AIMRC_INSEL_MSB:`AIMRC_INSEL_LSB] : positive_input_select;

  // -----------------------------------------------------------------
  // input select decode
  // -----------------------------------------------------------------
  aimrc_mux_decode #(
    .EXT_CHANNELS (EXT_CHANNELS),
    .INT_SOURCES  (INT_SOURCES)
  ) u_decode (
    .code       (next_sel),
    .ext_select (next_ext),
    .int_select (next_int),
    .connected  (next_connected)
  );

  // -----------------------------------------------------------------
  // input select register
  // -----------------------------------------------------------------
  // decoded select registered
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      positive_input_select    <= 5'(`AIMRC_INSEL_RESET);
      ext_channel_select       <= '0;
      internal_source_select   <= '0;
      positive_input_connected <= 1'b0;
    end else begin
      positive_input_select    <= next_sel;
      ext_channel_select       <= next_ext;
      internal_source_select   <= next_int;
      positive_input_connected <= next_connected;
    end
  end

  // -----------------------------------------------------------------
  // reference control register
  // -----------------------------------------------------------------
  // field stores
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      internal_ref_level      <= 1'(`AIMRC_REFCTL_RESET >> `AIMRC_REF_LEVEL_BIT);
      ground_ref_select       <= 1'(`AIMRC_REFCTL_RESET >> `AIMRC_GND_SEL_BIT);
      reference_source_select <= aimrc_pkg::aimrc_ref_src_t'(2'(`AIMRC_REFCTL_RESET >> `AIMRC_REF_SRC_LSB));
      temp_sensor_enable      <= 1'(`AIMRC_REFCTL_RESET >> `AIMRC_TEMP_EN_BIT);
    end else if (wr_refctl) begin
      internal_ref_level      <= sfr_wdata[`AIMRC_REF_LEVEL_BIT];
      ground_ref_select       <= sfr_wdata[`AIMRC_GND_SEL_BIT];
      reference_source_select <= aimrc_pkg::aimrc_ref_src_t'(sfr_wdata[`AIMRC_REF_SRC_MSB:`AIMRC_REF_SRC_LSB]);
      temp_sensor_enable      <= sfr_wdata[`AIMRC_TEMP_EN_BIT];
    end
  end

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  logic [7:0] refctl_view;

  always_comb begin
    refctl_view = '0;
    refctl_view[`AIMRC_REF_LEVEL_BIT] = internal_ref_level;
    refctl_view[`AIMRC_GND_SEL_BIT]   = ground_ref_select;
    refctl_view[`AIMRC_REF_SRC_MSB:`AIMRC_REF_SRC_LSB] = reference_source_select;
    refctl_view[`AIMRC_TEMP_EN_BIT]   = temp_sensor_enable;
  end

  // reserved bits read zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= `AIMRC_RDATA_NONE;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        `AIMRC_ADDR_INSEL: begin
          sfr_rdata <= {3'h0, positive_input_select} & `AIMRC_INSEL_WMASK;
        end
        `AIMRC_ADDR_REFCTL: begin
          sfr_rdata <= refctl_view & `AIMRC_REFCTL_WMASK;
        end
        default: begin
          sfr_rdata <= `AIMRC_RDATA_NONE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_ext_channel;
    @(posedge clk) disable iff (sys_rst)
      (positive_input_select <= `AIMRC_CODE_EXT_LAST) |->
        (ext_channel_select == (`AIMRC_EXT_ONE << positive_input_select))
        && (internal_source_select == '0) && positive_input_connected;
  endproperty
  a_ext_channel: assert property (p_ext_channel) else $error("external channel decode wrong");

  property p_int_source;
    @(posedge clk) disable iff (sys_rst)
      (positive_input_select >= `AIMRC_CODE_INT_FIRST && positive_input_select <= `AIMRC_CODE_INT_LAST) |->
        (internal_source_select == (`AIMRC_INT_ONE << positive_input_select[1:0]))
        && (ext_channel_select == '0) && positive_input_connected;
  endproperty
  a_int_source: assert property (p_int_source) else $error("internal source decode wrong");

  property p_reserved_code;
    @(posedge clk) disable iff (sys_rst)
      (positive_input_select > `AIMRC_CODE_INT_LAST) |->
        (ext_channel_select == '0) && (internal_source_select == '0) && !positive_input_connected;
  endproperty
  a_reserved_code: assert property (p_reserved_code) else $error("reserved code connects an input");

  property p_ref_level;
    @(posedge clk) disable iff (sys_rst)
      wr_refctl |=> (internal_ref_level == $past(sfr_wdata[`AIMRC_REF_LEVEL_BIT]));
  endproperty
  a_ref_level: assert property (p_ref_level) else $error("reference level not taken");

  property p_gnd_sel;
    @(posedge clk) disable iff (sys_rst)
      wr_refctl ##1 !wr_refctl |=> $stable(ground_ref_select)
        && (ground_ref_select == $past(sfr_wdata[`AIMRC_GND_SEL_BIT], 2));
  endproperty
  a_gnd_sel: assert property (p_gnd_sel) else $error("ground select not held");

  property p_ref_src;
    @(posedge clk) disable iff (sys_rst)
      wr_refctl |=> (reference_source_select == $past(sfr_wdata[`AIMRC_REF_SRC_MSB:`AIMRC_REF_SRC_LSB]));
  endproperty
  a_ref_src: assert property (p_ref_src) else $error("reference source not taken");

  property p_temp_en;
    @(posedge clk) disable iff (sys_rst)
      !wr_refctl |=> $stable(temp_sensor_enable);
  endproperty
  a_temp_en: assert property (p_temp_en) else $error("temp enable changed without write");

  property p_sel_update;
    @(posedge clk) disable iff (sys_rst)
      wr_insel |=> (positive_input_select == $past(sfr_wdata[`AIMRC_INSEL_MSB:`AIMRC_INSEL_LSB]))
        ##1 $stable(positive_input_select) || $past(wr_insel);
  endproperty
  a_sel_update: assert property (p_sel_update) else $error("select not updated after write");

  property p_temp_take;
    @(posedge clk) disable iff (sys_rst)
      wr_refctl |=> (temp_sensor_enable == $past(sfr_wdata[`AIMRC_TEMP_EN_BIT]));
  endproperty
  a_temp_take: assert property (p_temp_take) else $error("temp enable not taken");

  property p_refctl_hold;
    @(posedge clk) disable iff (sys_rst)
      !wr_refctl |=> $stable(internal_ref_level) && $stable(ground_ref_select)
        && $stable(reference_source_select);
  endproperty
  a_refctl_hold: assert property (p_refctl_hold) else $error("reference fields changed without write");

  property p_sel_hold;
    @(posedge clk) disable iff (sys_rst)
      !wr_insel |=> $stable(positive_input_select);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select changed without write");

  property p_rd_insel;
    @(posedge clk) disable iff (sys_rst)
      (sfr_rd && sfr_addr == `AIMRC_ADDR_INSEL) |=>
        (sfr_rdata == {3'h0, $past(positive_input_select)});
  endproperty
  a_rd_insel: assert property (p_rd_insel) else $error("input select read back wrong");

  property p_rd_refctl;
    @(posedge clk) disable iff (sys_rst)
      (sfr_rd && sfr_addr == `AIMRC_ADDR_REFCTL) |=>
        (sfr_rdata[`AIMRC_REF_LEVEL_BIT] == $past(internal_ref_level))
        && (sfr_rdata[`AIMRC_GND_SEL_BIT] == $past(ground_ref_select))
        && (sfr_rdata[`AIMRC_REF_SRC_MSB:`AIMRC_REF_SRC_LSB] == $past(reference_source_select))
        && (sfr_rdata[`AIMRC_TEMP_EN_BIT] == $past(temp_sensor_enable))
        && ((sfr_rdata & ~`AIMRC_REFCTL_WMASK) == `AIMRC_RDATA_NONE);
  endproperty
  a_rd_refctl: assert property (p_rd_refctl) else $error("reference control read back wrong");

endmodule

// file: bench/tb_top.sv
// self-checking bench for the input mux and reference control block
`timescale 1ns/1ps
`include "aimrc_consts.svh"

module tb_top;
  // ---------------------------------------------------------------
  // signals and bench state
  // ---------------------------------------------------------------
  localparam logic [38:0] M_RD   = 39'h7F80000000;
  localparam logic [38:0] M_EXT  = 39'h007FFFFC00;
  localparam logic [38:0] M_INT  = 39'h00000003C0;
  localparam logic [38:0] M_CONN = 39'h0000000020;
  localparam logic [38:0] M_LVL  = 39'h0000000010;
  localparam logic [38:0] M_GND  = 39'h0000000008;
  localparam logic [38:0] M_SRC  = 39'h0000000006;
  localparam logic [38:0] M_TEMP = 39'h0000000001;

  logic                      clk       = 1'b0;
  logic                      sys_rst   = 1'b1;
  logic [7:0]                sfr_addr  = 8'h00;
  logic [7:0]                sfr_wdata = 8'h00;
  logic                      sfr_wr    = 1'b0;
  logic                      sfr_rd    = 1'b0;
  logic [7:0]                sfr_rdata;
  logic [4:0]                positive_input_select;
  logic [15:0]               ext_channel_select;
  logic [3:0]                internal_source_select;
  logic                      positive_input_connected;
  logic                      internal_ref_level;
  logic                      ground_ref_select;
  aimrc_pkg::aimrc_ref_src_t reference_source_select;
  logic                      temp_sensor_enable;
  logic [38:0]               notes[$];
  logic [38:0]               pend;
  logic [38:0]               e;
  logic [7:0]                ins  = 8'h1F;
  logic [7:0]                refc = 8'h18;
  logic [7:0]                rdm  = 8'h00;
  logic                      have = 1'b0;
  int                        mismatches = 0;
  int                        tests_run  = 0;
  int                        seed       = 69;
  wire logic [38:0]          obs = {sfr_rdata, positive_input_select, ext_channel_select, internal_source_select,
                                    positive_input_connected, internal_ref_level, ground_ref_select,
                                    reference_source_select, temp_sensor_enable};

  always #10 clk = ~clk;

  aimrc_top i_aimrc_top (
    .clk                      (clk),
    .sys_rst                  (sys_rst),
    .sfr_addr                 (sfr_addr),
    .sfr_wdata                (sfr_wdata),
    .sfr_wr                   (sfr_wr),
    .sfr_rd                   (sfr_rd),
    .sfr_rdata                (sfr_rdata),
    .positive_input_select    (positive_input_select),
    .ext_channel_select       (ext_channel_select),
    .internal_source_select   (internal_source_select),
    .positive_input_connected (positive_input_connected),
    .internal_ref_level       (internal_ref_level),
    .ground_ref_select        (ground_ref_select),
    .reference_source_select  (reference_source_select),
    .temp_sensor_enable       (temp_sensor_enable)
  );

  // ---------------------------------------------------------------
  // expectation model, driver and checker
  // ---------------------------------------------------------------
  function automatic logic [38:0] expv();
    logic [4:0]  c;
    logic [15:0] x;
    logic [3:0]  i;
    c = ins[4:0];
    x = (c < 5'h10) ? (16'h0001 << c) : 16'h0000;
    i = (c[4:2] == 3'b100) ? (4'h1 << c[1:0]) : 4'h0;
    return {rdm, c, x, i, c < 5'h14, refc[7], refc[5], refc[4:3], refc[2]};
  endfunction

  task automatic check(input logic [38:0] seen, input logic [38:0] exp, input logic [38:0] m);
    tests_run++;
    if ((seen & m) !== (exp & m)) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen & m, exp & m);
    end
  endtask

  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    if (have) notes.push_back(pend);
    sfr_wr = w;
    sfr_rd = r;
    sfr_addr = a;
    sfr_wdata = d;
    if (r) rdm = (a == `AIMRC_ADDR_INSEL) ? ins : (a == `AIMRC_ADDR_REFCTL) ? refc : 8'h00;
    if (w && a == `AIMRC_ADDR_INSEL) ins = d & 8'h1F;
    if (w && a == `AIMRC_ADDR_REFCTL) refc = d & 8'hBC;
    pend = expv();
    have = 1'b1;
  endtask

  task automatic rst_pulse();
    @(negedge clk);
    sys_rst = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    have = 1'b0;
    ins = 8'h1F;
    refc = 8'h18;
    rdm = 8'h00;
    notes.push_back(expv());
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
  endtask

  always @(negedge clk) begin
    #2;
    while (notes.size() > 0) begin
      e = notes.pop_front();
      check(obs, e, M_RD);
      check(obs, e, M_EXT);
      check(obs, e, M_INT);
      check(obs, e, M_CONN);
      check(obs, e, M_LVL);
      check(obs, e, M_GND);
      check(obs, e, M_SRC);
      check(obs, e, M_TEMP);
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #40000;
    mismatches++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] a;
    logic [7:0] d;
    rst_pulse();
    op(0, 1, `AIMRC_ADDR_INSEL, 8'h00);
    op(0, 1, `AIMRC_ADDR_REFCTL, 8'h00);
    op(0, 1, 8'h5A, 8'h00);
    for (int k = 0; k < 32; k++) begin
      op(1, 0, `AIMRC_ADDR_INSEL, 8'(k));
      op(0, 1, `AIMRC_ADDR_INSEL, 8'h00);
    end
    for (int k = 0; k < 32; k++) begin
      d = {k[4], 1'b0, k[3], k[2:1], k[0], 2'b00};
      op(1, 1, `AIMRC_ADDR_REFCTL, d);
      op(0, 1, `AIMRC_ADDR_REFCTL, 8'h00);
    end
    op(1, 1, 8'hD2, 8'hFF);
    for (int k = 0; k < 80; k++) begin
      d = 8'($random(seed));
      a = 8'($random(seed));
      case (a[1:0])
        2'b00: a = `AIMRC_ADDR_INSEL;
        2'b01: a = `AIMRC_ADDR_REFCTL;
        default: a = (a == `AIMRC_ADDR_INSEL || a == `AIMRC_ADDR_REFCTL) ? 8'h00 : a;
      endcase
      if (a == `AIMRC_ADDR_INSEL) d = d & 8'h1F;
      if (a == `AIMRC_ADDR_REFCTL) d = d & 8'hBC;
      op(d[7] | d[0], d[6] ^ a[2], a, d);
      if (k == 40) rst_pulse();
    end
    op(0, 0, 8'h00, 8'h00);
    op(0, 0, 8'h00, 8'h00);
    repeat (2) @(negedge clk);
    stop_test();
  end
endmodule
